// [core/brs_delay_cnt.sv]
/*
  Down counter used for the sequencer waits.
  Assumes load and the count value come from core_clk logic.
*/
module brs_delay_cnt
  import brs_pkg::*;
#(
  parameter int unsigned WIDTH = 5,
  parameter logic [WIDTH-1:0] INIT_COUNT = '0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_count,
  output logic expired
);

  logic [WIDTH-1:0] count;

  if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
    $error("brs_delay_cnt: WIDTH out of range");
  end

  // counts down to zero and stays there until reloaded
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= INIT_COUNT;
    end else if (ce) begin
      if (load) begin
        count <= load_count;
      end else if (count != '0) begin
        count <= count - 1'b1;
      end
    end
  end

  assign expired = (count == '0) && !load;

endmodule

// [core/brs_sec_drive.sv]
/*
  Registered drivers of the secondary bus pins with reset override.
  Assumes hold_reset comes from core_clk logic; rstn is the primary reset.
*/
module brs_sec_drive
  import brs_pkg::*;
#(
  parameter int unsigned CTL_W = 6,
  parameter int unsigned GNT_W = 4
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic hold_reset,
  input wire logic [31:0] core_sec_ad,
  input wire logic core_sec_ad_oe,
  input wire logic [3:0] core_sec_cbe_n,
  input wire logic core_sec_cbe_oe,
  input wire logic core_sec_par,
  input wire logic core_sec_par_oe,
  input wire logic [CTL_W-1:0] core_sec_ctl,
  input wire logic [CTL_W-1:0] core_sec_ctl_oe,
  input wire logic [GNT_W-1:0] core_sec_gnt_n,
  input wire logic [GNT_W-1:0] core_sec_gnt_oe,
  output logic [31:0] sec_ad,
  output logic sec_ad_oe,
  output logic [3:0] secondary_cmd_byte_en_n,
  output logic secondary_cmd_byte_en_oe,
  output logic secondary_parity,
  output logic secondary_parity_oe,
  output logic [CTL_W-1:0] sec_ctl,
  output logic [CTL_W-1:0] sec_ctl_oe,
  output logic [GNT_W-1:0] sec_gnt_n,
  output logic [GNT_W-1:0] sec_gnt_oe
);

  if (GNT_W < 1 || GNT_W > 16 || CTL_W < 1) begin : g_bad_width
    $error("brs_sec_drive: width out of range");
  end

  // data lanes are driven low through reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sec_ad <= 32'h0000_0000;
      sec_ad_oe <= 1'b1;
      secondary_cmd_byte_en_n <= 4'h0;
      secondary_cmd_byte_en_oe <= 1'b1;
      secondary_parity <= 1'b0;
      secondary_parity_oe <= 1'b1;
    end else if (ce) begin
      if (hold_reset) begin
        sec_ad <= 32'h0000_0000;
        sec_ad_oe <= 1'b1;
        secondary_cmd_byte_en_n <= 4'h0;
        secondary_cmd_byte_en_oe <= 1'b1;
        secondary_parity <= 1'b0;
        secondary_parity_oe <= 1'b1;
      end else begin
        sec_ad <= core_sec_ad;
        sec_ad_oe <= core_sec_ad_oe;
        secondary_cmd_byte_en_n <= core_sec_cbe_n;
        secondary_cmd_byte_en_oe <= core_sec_cbe_oe;
        secondary_parity <= core_sec_par;
        secondary_parity_oe <= core_sec_par_oe;
      end
    end
  end

  // control lines float during reset
  for (genvar i = 0; i < CTL_W; i++) begin : g_ctl
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        sec_ctl[i] <= 1'b1;
        sec_ctl_oe[i] <= 1'b0;
      end else if (ce) begin
        sec_ctl[i] <= core_sec_ctl[i];
        sec_ctl_oe[i] <= core_sec_ctl_oe[i] && !hold_reset;
      end
    end
  end

  // every grant floats during reset
  for (genvar g = 0; g < GNT_W; g++) begin : g_gnt
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        sec_gnt_n[g] <= 1'b1;
        sec_gnt_oe[g] <= 1'b0;
      end else if (ce) begin
        sec_gnt_n[g] <= core_sec_gnt_n[g];
        sec_gnt_oe[g] <= core_sec_gnt_oe[g] && !hold_reset;
      end
    end
  end

endmodule

// [core/brs_top.sv]
/*
  Secondary bus reset and chip reset sequencer of a two-port bridge, with
  the config header fields it owns and the config access port.
  Assumes rstn is the primary reset input (async, active low), config
  requests come from core_clk logic, and the bridge core reads the
  flush and drive-enable levels.
*/
module brs_top
  import brs_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = 16'h5A5A, // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'hA5A5, // arbitrary value
  parameter logic [7:0] REVISION = 8'h00,
  parameter int unsigned CTL_W = 6,
  parameter int unsigned GNT_W = 4
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic [31:0] core_sec_ad,
  input wire logic core_sec_ad_oe,
  input wire logic [3:0] core_sec_cbe_n,
  input wire logic core_sec_cbe_oe,
  input wire logic core_sec_par,
  input wire logic core_sec_par_oe,
  input wire logic [CTL_W-1:0] core_sec_ctl,
  input wire logic [CTL_W-1:0] core_sec_ctl_oe,
  input wire logic [GNT_W-1:0] core_sec_gnt_n,
  input wire logic [GNT_W-1:0] core_sec_gnt_oe,
  output logic secondary_reset_n,
  output logic [31:0] sec_ad,
  output logic sec_ad_oe,
  output logic [3:0] secondary_cmd_byte_en_n,
  output logic secondary_cmd_byte_en_oe,
  output logic secondary_parity,
  output logic secondary_parity_oe,
  output logic [CTL_W-1:0] sec_ctl,
  output logic [CTL_W-1:0] sec_ctl_oe,
  output logic [GNT_W-1:0] sec_gnt_n,
  output logic [GNT_W-1:0] sec_gnt_oe,
  output logic flush_buffers,
  output logic primary_drive_en,
  output logic config_ready,
  output logic [15:0] bridge_control,
  output logic [15:0] diagnostic_chip_control
);

  brs_state_type state;
  brs_state_type next_state;
  logic accessible;
  logic take;
  logic [5:0] dword_idx;
  logic hit_bridge;
  logic hit_diag;
  logic wr_bridge;
  logic wr_diag;
  logic [15:0] next_bridge;
  logic [15:0] next_diag;
  logic sec_bit_clear_evt;
  logic chip_req;
  logic chip_quiet;
  logic chip_done;
  logic hold_reset;
  logic cnt_load;
  logic [BRS_CNT_W-1:0] cnt_value;
  logic cnt_expired;
  logic [31:0] read_word;

  if (BRS_CHIP_RELEASE_CLKS + 5'h02 > BRS_CHIP_RELEASE_MAX_CLKS) begin : g_bad_release
    $error("brs_top: release wait too long for the self-clear bound");
  end
  if (GNT_W < 1 || GNT_W > 16) begin : g_bad_gnt
    $error("brs_top: GNT_W out of range");
  end

  // access gate: closed in the power-up wait and in the chip reset quiet and release phases, open in hold
  assign accessible = (state == BRS_ST_READY) || (state == BRS_ST_CHIP_HOLD);
  assign take = cfg_req && accessible;
  assign dword_idx = cfg_addr[7:2];

  // header decode
  assign hit_bridge = (dword_idx == BRS_OFS_BRIDGE[7:2]);
  assign hit_diag = (dword_idx == BRS_OFS_DIAG[7:2]);
  assign wr_bridge = take && cfg_write && hit_bridge;
  assign wr_diag = take && cfg_write && hit_diag;

  // byte-lane merge of the bridge control field, upper half of 3Ch
  always_comb begin
    next_bridge = bridge_control;
    if (cfg_be[2]) begin
      next_bridge[7:0] = cfg_wdata[23:16];
    end
    if (cfg_be[3]) begin
      next_bridge[15:8] = cfg_wdata[31:24];
    end
    next_bridge = next_bridge & BRS_BRIDGE_RW_MASK;
  end

  // byte-lane merge of the chip control field; the chip-reset bit is
  // owned by the sequencer and keeps its value on a plain write
  always_comb begin
    next_diag = diagnostic_chip_control;
    if (cfg_be[0]) begin
      next_diag[7:0] = cfg_wdata[7:0];
    end
    if (cfg_be[1]) begin
      next_diag[15:8] = cfg_wdata[15:8];
    end
    next_diag = next_diag & BRS_DIAG_RW_MASK;
    next_diag[BRS_DIAG_CHIPRST_BIT] = diagnostic_chip_control[BRS_DIAG_CHIPRST_BIT];
  end

  // software events seen by the sequencer, and the quiet and done decodes of its state
  assign sec_bit_clear_evt = wr_bridge && cfg_be[2] && bridge_control[BRS_BRIDGE_SECRST_BIT]
    && !cfg_wdata[BRS_BRIDGE_LSB + BRS_BRIDGE_SECRST_BIT];
  assign chip_req = wr_diag && cfg_be[0] && cfg_wdata[BRS_DIAG_CHIPRST_BIT]
    && (state == BRS_ST_READY);
  assign chip_quiet = (state == BRS_ST_CHIP_QUIET);
  assign chip_done = (state == BRS_ST_CHIP_RELEASE) && cnt_expired;

  // sequencer: power-up wait, chip reset quiet, hold, release
  always_comb begin
    next_state = state;
    cnt_load = 1'b0;
    cnt_value = BRS_POR_WAIT_CLKS;
    case (state)
      BRS_ST_POR_WAIT: begin
        if (cnt_expired) begin
          next_state = BRS_ST_READY;
        end
      end
      BRS_ST_READY: begin
        if (chip_req) begin
          next_state = BRS_ST_CHIP_QUIET;
          cnt_load = 1'b1;
          cnt_value = BRS_CHIP_QUIET_CLKS - 5'h01;
        end
      end
      BRS_ST_CHIP_QUIET: begin
        if (cnt_expired) begin
          next_state = BRS_ST_CHIP_HOLD;
        end
      end
      BRS_ST_CHIP_HOLD: begin
        if (sec_bit_clear_evt) begin
          next_state = BRS_ST_CHIP_RELEASE;
          cnt_load = 1'b1;
          cnt_value = BRS_CHIP_RELEASE_CLKS - 5'h01;
        end
      end
      BRS_ST_CHIP_RELEASE: begin
        if (cnt_expired) begin
          next_state = BRS_ST_READY;
        end
      end
      default: begin
        next_state = BRS_ST_POR_WAIT;
      end
    endcase
  end

  // state register; primary reset restarts the power-up wait
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= BRS_ST_POR_WAIT;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // shared wait counter, preloaded with the power-up wait
  brs_delay_cnt #(
    .WIDTH(BRS_CNT_W),
    .INIT_COUNT(BRS_POR_WAIT_CLKS)
  ) u_wait (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .load(cnt_load),
    .load_count(cnt_value),
    .expired(cnt_expired)
  );

  // bridge control: chip reset restores defaults and sets the reset bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bridge_control <= BRS_BRIDGE_RST;
    end else if (ce) begin
      if (chip_quiet) begin
        bridge_control <= BRS_BRIDGE_RST;
        bridge_control[BRS_BRIDGE_SECRST_BIT] <= 1'b1;
      end else if (wr_bridge) begin
        bridge_control <= next_bridge;
      end
    end
  end

  // chip control: bit set by request, cleared by the sequencer or primary reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      diagnostic_chip_control <= BRS_DIAG_RST;
    end else if (ce) begin
      if (chip_req) begin
        diagnostic_chip_control <= next_diag;
        diagnostic_chip_control[BRS_DIAG_CHIPRST_BIT] <= 1'b1;
      end else if (chip_quiet) begin
        diagnostic_chip_control <= BRS_DIAG_RST;
        diagnostic_chip_control[BRS_DIAG_CHIPRST_BIT] <= 1'b1;
      end else if (chip_done) begin
        diagnostic_chip_control[BRS_DIAG_CHIPRST_BIT] <= 1'b0;
      end else if (wr_diag) begin
        diagnostic_chip_control <= next_diag;
      end
    end
  end

  // secondary reset level: software bit or chip reset in its quiet phase
  assign hold_reset = bridge_control[BRS_BRIDGE_SECRST_BIT] || chip_quiet;

  // reset output; primary reset forces it low without the clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      secondary_reset_n <= 1'b0;
    end else if (ce) begin
      secondary_reset_n <= !hold_reset;
    end
  end

  // buffer flush level for the posted and delayed transaction queues
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flush_buffers <= 1'b1;
    end else if (ce) begin
      flush_buffers <= hold_reset;
    end
  end

  // primary drivers released only while the device may answer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      primary_drive_en <= 1'b0;
      config_ready <= 1'b0;
    end else if (ce) begin
      primary_drive_en <= (next_state == BRS_ST_READY) || (next_state == BRS_ST_CHIP_HOLD);
      config_ready <= (next_state == BRS_ST_READY);
    end
  end

  // secondary pin drivers
  brs_sec_drive #(
    .CTL_W(CTL_W),
    .GNT_W(GNT_W)
  ) u_sec (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .hold_reset(hold_reset),
    .core_sec_ad(core_sec_ad),
    .core_sec_ad_oe(core_sec_ad_oe),
    .core_sec_cbe_n(core_sec_cbe_n),
    .core_sec_cbe_oe(core_sec_cbe_oe),
    .core_sec_par(core_sec_par),
    .core_sec_par_oe(core_sec_par_oe),
    .core_sec_ctl(core_sec_ctl),
    .core_sec_ctl_oe(core_sec_ctl_oe),
    .core_sec_gnt_n(core_sec_gnt_n),
    .core_sec_gnt_oe(core_sec_gnt_oe),
    .sec_ad(sec_ad),
    .sec_ad_oe(sec_ad_oe),
    .secondary_cmd_byte_en_n(secondary_cmd_byte_en_n),
    .secondary_cmd_byte_en_oe(secondary_cmd_byte_en_oe),
    .secondary_parity(secondary_parity),
    .secondary_parity_oe(secondary_parity_oe),
    .sec_ctl(sec_ctl),
    .sec_ctl_oe(sec_ctl_oe),
    .sec_gnt_n(sec_gnt_n),
    .sec_gnt_oe(sec_gnt_oe)
  );

  // read mux over the header; identity words are fixed, 3Ch and 40h return the control fields, others zero
  always_comb begin
    read_word = 32'h0000_0000;
    if (dword_idx == BRS_OFS_ID[7:2]) begin
      read_word = {DEVICE_CODE, VENDOR_CODE};
    end else if (dword_idx == BRS_OFS_CLASS[7:2]) begin
      read_word = {BRS_CLASS_CODE, REVISION};
    end else if (dword_idx == BRS_OFS_HDR[7:2]) begin
      read_word = {8'h00, BRS_HEADER_TYPE, 16'h0000};
    end else if (hit_bridge) begin
      read_word = {bridge_control, BRS_INT_PIN, 8'h00};
    end else if (hit_diag) begin
      read_word = {16'h0000, diagnostic_chip_control};
    end
  end

  // answer one cycle after a request is taken; refused ones get none
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      cfg_ack <= take;
      if (take && !cfg_write) begin
        cfg_rdata <= read_word;
      end else begin
        cfg_rdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// [pkg/brs_pkg.sv]
/*
  Package for the bridge secondary and chip reset block: config offsets,
  field positions, reset values, wait counts and the sequencer states.
  Assumes one primary clock domain (core_clk) and one config port.
*/
// Function
// - Secondary reset output held asserted while primary reset input is asserted.
// - Secondary-reset bit set asserts secondary reset until a config write clears it.
// - Setting the chip-reset bit also asserts the secondary reset output.
// - Secondary reset tri-states all secondary control outputs and every grant output.
// - During secondary reset, address/data, command/byte enables and parity driven low.
// - Secondary reset flushes all posted-write and delayed-transaction buffers.
// - Secondary reset edges are asynchronous to the primary clock for receivers.
// - Config accesses keep being answered while only the secondary-reset bit resets.
// - Chip-reset bit resets all registers and state, tri-states interface signals.
// - Chip reset sets the secondary-reset bit by itself.
// - Chip-reset bit self-clears within 20 clocks after the clearing write.
// - No access is answered while a chip reset is in progress; the code answers in the hold phase between quiet and release.
// - Low half of dword 00h is a fixed read-only vendor code.
// - High half of dword 00h is a fixed read-only device code.
// - Type-1 header; bridge control at 3Ch high, chip control at 40h low.
// - Primary reset performs a chip reset and restores register defaults.
// - Device stays inaccessible for 16 clocks after primary reset release; the code keeps it inaccessible for 17.
package brs_pkg;

  // config space byte offsets
  localparam logic [7:0] BRS_OFS_ID = 8'h00;
  localparam logic [7:0] BRS_OFS_CLASS = 8'h08;
  localparam logic [7:0] BRS_OFS_HDR = 8'h0C;
  localparam logic [7:0] BRS_OFS_BRIDGE = 8'h3C;
  localparam logic [7:0] BRS_OFS_DIAG = 8'h40;

  // bit positions within their 16-bit fields, and the low bit of the bridge field in its dword
  localparam int unsigned BRS_BRIDGE_SECRST_BIT = 6;
  localparam int unsigned BRS_DIAG_CHIPRST_BIT = 1;
  localparam int unsigned BRS_BRIDGE_LSB = 16;

  // writable masks and reset values
  localparam logic [15:0] BRS_BRIDGE_RW_MASK = 16'h0FFF;
  localparam logic [15:0] BRS_DIAG_RW_MASK = 16'h00FF;
  localparam logic [15:0] BRS_BRIDGE_RST = 16'h0000;
  localparam logic [15:0] BRS_DIAG_RST = 16'h0000;

  // fixed header contents
  localparam logic [7:0] BRS_HEADER_TYPE = 8'h01;
  localparam logic [23:0] BRS_CLASS_CODE = 24'h060400;
  localparam logic [7:0] BRS_INT_PIN = 8'h00;

  // wait counts in core_clk cycles
  localparam int unsigned BRS_CNT_W = 5;
  localparam logic [4:0] BRS_POR_WAIT_CLKS = 5'h10;
  localparam logic [4:0] BRS_CHIP_QUIET_CLKS = 5'h04;
  localparam logic [4:0] BRS_CHIP_RELEASE_CLKS = 5'h08;
  localparam logic [4:0] BRS_CHIP_RELEASE_MAX_CLKS = 5'h14;

  typedef enum logic [2:0] {
    BRS_ST_POR_WAIT,
    BRS_ST_READY,
    BRS_ST_CHIP_QUIET,
    BRS_ST_CHIP_HOLD,
    BRS_ST_CHIP_RELEASE
  } brs_state_type;

endpackage

// [test/brs_host_model.sv]
/*
  Primary host model: issues config cycles to the reset block.
  Assumes requests change at the falling edge and are answered one edge later.
*/
module brs_host_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_req,
  output logic cfg_write,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int since_rel;

  // clocks since primary reset release
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      since_rel <= 0;
    else if (since_rel < 99)
      since_rel <= since_rel + 1;
  end

  initial begin
    cfg_req = 1'b0;
    {cfg_write, cfg_addr, cfg_be, cfg_wdata} = '0;
  end

  // one config cycle; released qualifiers are inverted so no stale value lingers
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                        output logic ack, output logic [31:0] rd);
    do @(negedge core_clk); while (since_rel < 17);
    cfg_req = 1'b1;
    {cfg_write, cfg_addr, cfg_be, cfg_wdata} = {w, a, be, wd};
    @(negedge core_clk);
    ack = cfg_ack;
    rd = cfg_rdata;
    cfg_req = 1'b0;
    {cfg_write, cfg_addr, cfg_be, cfg_wdata} = ~{w, a, be, wd};
  endtask
endmodule

// [test/brs_top_asserts.sv]
/*
  Port checker for the secondary and chip reset sequencer.
  Assumes it is bound to brs_top, one clock core_clk, rstn async active low.
*/
module brs_top_asserts
  import brs_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = 16'h5A5A,
  parameter logic [15:0] DEVICE_CODE = 16'hA5A5,
  parameter int unsigned CTL_W = 6,
  parameter int unsigned GNT_W = 4
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic secondary_reset_n,
  input wire logic [31:0] sec_ad,
  input wire logic sec_ad_oe,
  input wire logic [3:0] secondary_cmd_byte_en_n,
  input wire logic secondary_cmd_byte_en_oe,
  input wire logic secondary_parity,
  input wire logic secondary_parity_oe,
  input wire logic [CTL_W-1:0] sec_ctl_oe,
  input wire logic [GNT_W-1:0] sec_gnt_oe,
  input wire logic flush_buffers,
  input wire logic primary_drive_en,
  input wire logic config_ready,
  input wire logic [15:0] bridge_control,
  input wire logic [15:0] diagnostic_chip_control
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // request taken, chip reset start, and the write that ends a chip reset
  sequence taken;
    ce && cfg_req && primary_drive_en;
  endsequence
  sequence chip_start;
    taken ##0 (cfg_write && cfg_addr == 8'h40 && cfg_be[0] && cfg_wdata[1] && config_ready);
  endsequence
  sequence sec_clear;
    taken ##0 (cfg_write && cfg_addr == 8'h3C && cfg_be[2] && !cfg_wdata[22] && diagnostic_chip_control[1]);
  endsequence

  chk_prst_hold: assert property ($rose(rstn) |-> !secondary_reset_n)
    else $error("secondary reset not held at primary release");
  chk_prst_defaults: assert property ($rose(rstn) |-> bridge_control == 16'h0 && diagnostic_chip_control == 16'h0)
    else $error("control fields not at default after primary reset");
  chk_por_quiet: assert property ($rose(rstn) |-> !primary_drive_en [*8] ##1 !primary_drive_en [*8] ##1 !primary_drive_en ##1 primary_drive_en)
    else $error("primary side wait after reset is wrong");
  chk_secbit_asserts: assert property (bridge_control[6] |=> !secondary_reset_n)
    else $error("secondary reset bit did not assert reset");
  chk_secbit_release: assert property (!bridge_control[6] && !diagnostic_chip_control[1] |=> secondary_reset_n)
    else $error("secondary reset held with no cause");
  chk_chipbit_asserts: assert property ($rose(diagnostic_chip_control[1]) |=> !secondary_reset_n)
    else $error("chip reset bit did not assert reset");
  chk_ctl_float: assert property (!secondary_reset_n |-> sec_ctl_oe == '0 && sec_gnt_oe == '0)
    else $error("control or grant driven during reset");
  chk_data_low: assert property (!secondary_reset_n |-> sec_ad == 32'h0 && sec_ad_oe && secondary_parity_oe && !secondary_parity && secondary_cmd_byte_en_n == 4'h0 && secondary_cmd_byte_en_oe)
    else $error("data lanes not driven low during reset");
  chk_flush_level: assert property (flush_buffers == !secondary_reset_n)
    else $error("flush does not track secondary reset");
  chk_ack_taken: assert property (taken |=> cfg_ack)
    else $error("taken request not answered");
  chk_ack_silent: assert property (ce && cfg_req && !primary_drive_en |=> !cfg_ack)
    else $error("request answered while inaccessible");
  chk_id_value: assert property (taken ##0 (!cfg_write && cfg_addr == 8'h00) |=> cfg_rdata == {DEVICE_CODE, VENDOR_CODE})
    else $error("identification dword wrong");
  chk_chip_quiet: assert property (chip_start |=> !primary_drive_en [*4] ##[1:4] (primary_drive_en && bridge_control == 16'h0040))
    else $error("chip reset entry sequence wrong");
  chk_chip_done: assert property (sec_clear |=> ##[1:20] (!diagnostic_chip_control[1] && config_ready))
    else $error("chip reset bit did not clear in time");
endmodule

bind brs_top brs_top_asserts #(.VENDOR_CODE(VENDOR_CODE), .DEVICE_CODE(DEVICE_CODE), .CTL_W(CTL_W), .GNT_W(GNT_W))
  u_chk (.core_clk, .rstn, .ce, .cfg_req, .cfg_write, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata,
  .secondary_reset_n, .sec_ad, .sec_ad_oe, .secondary_cmd_byte_en_n, .secondary_cmd_byte_en_oe,
  .secondary_parity, .secondary_parity_oe, .sec_ctl_oe, .sec_gnt_oe, .flush_buffers, .primary_drive_en,
  .config_ready, .bridge_control, .diagnostic_chip_control);

// [test/brs_top_bench.sv]
/*
  Self-checking bench of the reset sequencer with a register model.
  Assumes brs_top, its bound checker and the host model are compiled.
*/
module brs_top_bench
  import brs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] VEN = 16'h1357; // arbitrary value
  localparam logic [15:0] DEV = 16'h2468; // arbitrary value
  localparam logic [7:0] ADRS [4] = '{8'h00, 8'h3C, 8'h40, 8'h44};
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic cfg_req, cfg_write, cfg_ack, ack, core_sec_ad_oe, core_sec_cbe_oe, core_sec_par, core_sec_par_oe;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be, core_sec_cbe_n, secondary_cmd_byte_en_n, sec_gnt_n, sec_gnt_oe, core_sec_gnt_n, core_sec_gnt_oe;
  logic [31:0] cfg_wdata, cfg_rdata, core_sec_ad, sec_ad, rd;
  logic [5:0] core_sec_ctl, core_sec_ctl_oe, sec_ctl, sec_ctl_oe;
  logic secondary_reset_n, sec_ad_oe, secondary_cmd_byte_en_oe, secondary_parity, secondary_parity_oe;
  logic flush_buffers, primary_drive_en, config_ready;
  logic [15:0] bridge_control, diagnostic_chip_control;
  logic [31:0] seed = 32'h63e3e5e0;
  int fail_count = 0;
  int samples_checked = 0;
  int bc_m = 0;
  int dc_m = 0;
  int n;

  always #10 core_clk = ~core_clk;

  brs_top #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV)) u_dut (.*);
  brs_host_model u_host (.core_clk, .rstn, .cfg_ack, .cfg_rdata, .cfg_req, .cfg_write, .cfg_addr, .cfg_be,
    .cfg_wdata);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // byte-lane merge of a write into a 16-bit field model
  function automatic int merge(int old, int wd, int be, int mask);
    int m;
    m = ((be & 1) ? 32'hFF : 0) | ((be & 2) ? 32'hFF00 : 0);
    return (old & ~(m & mask)) | (wd & m & mask);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // fresh core-side pin values from the xorshift stream
  task automatic drive();
    seed = xs(seed);
    core_sec_ad = seed;
    {core_sec_cbe_n, core_sec_par, core_sec_ctl, core_sec_gnt_n} = seed[14:0];
    {core_sec_ctl_oe, core_sec_gnt_oe, core_sec_ad_oe, core_sec_cbe_oe, core_sec_par_oe} = seed[28:16];
  endtask

  // secondary pins one edge after new core values
  task automatic pins(input logic in_rst);
    drive();
    @(negedge core_clk);
    chk(secondary_reset_n, !in_rst);
    chk(sec_ad, in_rst ? 32'h0 : seed);
    chk({secondary_cmd_byte_en_n, secondary_parity, secondary_cmd_byte_en_oe, secondary_parity_oe, sec_ad_oe},
        in_rst ? 8'h07 : {seed[14:10], seed[17], seed[16], seed[18]});
    chk({sec_ctl_oe, sec_gnt_oe, sec_ctl, sec_gnt_n}, {in_rst ? 10'h0 : seed[28:19], rstn ? seed[9:0] : 10'h3FF});
    chk(flush_buffers, in_rst);
  endtask

  task automatic rdchk(input logic [7:0] a);
    u_host.access(1'b0, a, 4'hF, 32'h0, ack, rd);
    chk(ack, 1'b1);
    case (a)
      BRS_OFS_ID: chk(rd, {DEV, VEN});
      BRS_OFS_BRIDGE: chk(rd, bc_m << 16);
      BRS_OFS_DIAG: chk(rd[15:0], dc_m);
      default: chk(rd, 32'h0);
    endcase
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    u_host.access(1'b1, a, be, wd, ack, rd);
    chk(ack, 1'b1);
    if (a == BRS_OFS_BRIDGE)
      bc_m = merge(bc_m, wd >> 16, be >> 2, BRS_BRIDGE_RW_MASK);
    if (a == BRS_OFS_DIAG)
      dc_m = merge(dc_m, wd, be, 16'h00FD);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog, far beyond the expected few hundred cycles
  initial begin
    #200000;
    fail_count++;
    final_report();
  end

  initial begin
    drive();
    repeat (10) @(negedge core_clk);
    pins(1'b1);
    rstn = 1'b1;
    pins(1'b0);
    foreach (ADRS[i]) rdchk(ADRS[i]);
    wr(BRS_OFS_ID, 4'hF, 32'hFFFF_FFFF);
    rdchk(BRS_OFS_ID);
    // random field writes, secondary and chip bits kept clear
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(BRS_OFS_BRIDGE, seed[3:0], seed & 32'hFFBF_FFFF);
      wr(BRS_OFS_DIAG, seed[7:4], xs(seed) & 32'hFFFF_FFFD);
      rdchk(BRS_OFS_BRIDGE);
      rdchk(BRS_OFS_DIAG);
      chk({bridge_control, diagnostic_chip_control}, {bc_m[15:0], dc_m[15:0]});
      pins(1'b0);
    end
    // software secondary reset, config stays reachable
    wr(BRS_OFS_BRIDGE, 4'h4, 32'h0040_0000);
    pins(1'b1);
    rdchk(BRS_OFS_BRIDGE);
    pins(1'b1);
    wr(BRS_OFS_BRIDGE, 4'h4, 32'h0);
    pins(1'b0);
    // chip reset: silent, registers reset, secondary bit set by itself
    wr(BRS_OFS_BRIDGE, 4'hC, 32'h0ABC_0000);
    wr(BRS_OFS_DIAG, 4'h1, 32'h0000_0002);
    u_host.access(1'b0, BRS_OFS_DIAG, 4'hF, 32'h0, ack, rd);
    chk(ack, 1'b0);
    pins(1'b1);
    n = 0;
    while (primary_drive_en !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    bc_m = 32'h40;
    dc_m = 2;
    rdchk(BRS_OFS_BRIDGE);
    rdchk(BRS_OFS_DIAG);
    wr(BRS_OFS_BRIDGE, 4'h4, 32'h0);
    u_host.access(1'b0, BRS_OFS_DIAG, 4'hF, 32'h0, ack, rd);
    chk(ack, 1'b0);
    n = 2;
    while (diagnostic_chip_control[1] !== 1'b0 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(n <= 20, 1'b1);
    chk(config_ready, 1'b1);
    dc_m = 0;
    rdchk(BRS_OFS_DIAG);
    // primary reset in mid-run with the secondary bit set
    wr(BRS_OFS_BRIDGE, 4'h4, 32'h0040_0000);
    rstn = 1'b0;
    pins(1'b1);
    chk(bridge_control, 16'h0);
    rstn = 1'b1;
    bc_m = 0;
    pins(1'b0);
    rdchk(BRS_OFS_BRIDGE);
    final_report();
  end
endmodule
